//--- hdl/rcr_map.vh
// What this block does
// [RULE_01] converter sleep field: 00 normal, 11 sleep-pin
// [RULE_02] software never writes sleep codes 01, 10
// [RULE_03] software writes converter bits 3:2 as 11
// [RULE_04] converter bit 1: 0 auto, 1 forced pwm
// [RULE_05] converter bit 0 low forces rail off
// [RULE_06] linear two field 5:4 selects sleep setpoint
// [RULE_07] software writes linear bits 3:1 as 110
// [RULE_08] linear two bit 0 low forces off
// [RULE_09] linear three field selects sleep setpoint
// [RULE_10] linear three bit 0 low forces off
// [RULE_11] sleep pin fixed by factory, not software
// [RULE_12] bits 7:6 read zero, writes ignored
`ifndef RCR_MAP_VH
`define RCR_MAP_VH
`define RCR_IDX_CONV6      8'h27
`define RCR_IDX_LIN2       8'h28
`define RCR_IDX_LIN3       8'h29
`define RCR_IDX_STATUS     8'h2a
`define RCR_RST_CONV6      8'h0c
`define RCR_RST_LIN2       8'h0c
`define RCR_RST_LIN3       8'h0c
`define RCR_WMASK          8'h3f
`define RCR_SLP_HI         5
`define RCR_SLP_LO         4
`define RCR_MODE_BIT       1
`define RCR_KILL_BIT       0
`define RCR_SLP_ON         2'h3
`define RCR_ADDR_IDX_HI    11
`define RCR_ADDR_IDX_LO    2
`define RCR_BYTE_HI        7
`define RCR_EN_IDLE        3'h0
`define RCR_SLP_IDLE       2'h3
`define RCR_SEL_RST        3'h0
`endif

//--- hdl/rcr_rail.v
`default_nettype none
// per-rail decode of one control register
module rcr_rail (
  input  wire [7:0] ctrl,
  input  wire       en_pin,
  input  wire       sleep_pin_n,
  output wire       rail_on,
  output wire       use_sleep,
  output wire       bad_code
);
`include "rcr_map.vh"
  wire [1:0] sel;
  assign sel = ctrl[`RCR_SLP_HI:`RCR_SLP_LO];
  // sleep setpoint only with code 11 and pin low
  // [RULE_01] [RULE_06] [RULE_09] setpoint choice
  assign use_sleep = (sel == `RCR_SLP_ON) && !sleep_pin_n;
  // reserved codes flagged, treated as normal
  assign bad_code  = sel[1] ^ sel[0];
  // [RULE_05] [RULE_08] [RULE_10] kill overrides pins
  assign rail_on   = ctrl[`RCR_KILL_BIT] & en_pin;
endmodule
`default_nettype wire

//--- hdl/rcr_top.v
// The APB slave port was decided locally.
`default_nettype none
// three rail control registers behind apb
module rcr_top #(
  parameter SLEEP_PIN_SEL = 3'h0  // factory choice: bit set = second sleep pin
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [2:0]  rail_enable_pins,
  input  wire        sleep_pin_first,
  input  wire        sleep_pin_second,
  output reg  [2:0]  rail_on_q,
  output reg  [2:0]  rail_sleep_q,
  output reg         conv_six_pwm_force
);
`include "rcr_map.vh"

  // word index width: byte address without its alignment bits
  localparam IDX_W = `RCR_ADDR_IDX_HI - `RCR_ADDR_IDX_LO + 1;

  // true when a word index names the given register index
  function is_reg;
    input [IDX_W-1:0] word_idx;
    input [7:0]       reg_idx;
    begin
      is_reg = (word_idx == {{(IDX_W - 8){1'b0}}, reg_idx});
    end
  endfunction

  // true when a word index lies inside the mapped window
  function in_window;
    input [IDX_W-1:0] word_idx;
    begin
      in_window = (word_idx >= {{(IDX_W - 8){1'b0}}, `RCR_IDX_CONV6})
                  && (word_idx <= {{(IDX_W - 8){1'b0}}, `RCR_IDX_STATUS});
    end
  endfunction

  // control registers and their next values
  reg  [7:0]       conv6_q;
  reg  [7:0]       lin2_q;
  reg  [7:0]       lin3_q;
  reg  [7:0]       conv6_d;
  reg  [7:0]       lin2_d;
  reg  [7:0]       lin3_d;

  // two-stage synchronisers for the asynchronous pins
  reg  [2:0]       en_m_q;
  reg  [2:0]       en_s_q;
  reg  [1:0]       slp_m_q;
  reg  [1:0]       slp_s_q;

  // factory sleep pin choice, latched once after reset
  reg  [2:0]       sel_q;
  reg              sel_done_q;

  // read data ahead of its capture flop
  reg  [31:0]      prdata_d;

  // per-rail decode results and the sleep pin each rail listens to
  wire [2:0]       on_d;
  wire [2:0]       slp_d;
  wire [2:0]       bad;
  wire [2:0]       rail_slp_n;

  // bus phase and address decode
  wire [IDX_W-1:0] idx;
  wire             setup;
  wire             acc;
  wire             hit;
  wire             wr_en;
  wire             wr_conv6;
  wire             wr_lin2;
  wire             wr_lin3;

  // apb phase and address decode
  assign idx      = paddr[`RCR_ADDR_IDX_HI:`RCR_ADDR_IDX_LO];
  assign setup    = psel & ~penable;
  assign acc      = psel & penable;
  assign hit      = (paddr[`RCR_ADDR_IDX_LO-1:0] == 2'h0) && in_window(idx);
  // a write lands at the edge that ends its access cycle
  assign wr_en    = acc & pwrite & hit;
  assign wr_conv6 = wr_en & is_reg(idx, `RCR_IDX_CONV6);
  assign wr_lin2  = wr_en & is_reg(idx, `RCR_IDX_LIN2);
  assign wr_lin3  = wr_en & is_reg(idx, `RCR_IDX_LIN3);
  // zero wait states; unmapped or unaligned access answers with an error
  assign pready   = 1'b1;
  assign pslverr  = acc & ~hit;

  // pin synchronisers: only the second stage feeds any logic
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_m_q  <= `RCR_EN_IDLE;
      en_s_q  <= `RCR_EN_IDLE;
      slp_m_q <= `RCR_SLP_IDLE;
      slp_s_q <= `RCR_SLP_IDLE;
    end else begin
      en_m_q  <= rail_enable_pins;
      en_s_q  <= en_m_q;
      slp_m_q <= {sleep_pin_second, sleep_pin_first};
      slp_s_q <= slp_m_q;
    end
  end

  // [RULE_11] strap latched after reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q      <= `RCR_SEL_RST;
      sel_done_q <= 1'b0;
    end else if (!sel_done_q) begin
      sel_q      <= SLEEP_PIN_SEL;
      sel_done_q <= 1'b1;
    end
  end

  // next values; bits 5:0 are stored as written
  // [RULE_12] top bits masked on every write
  always @* begin
    conv6_d = conv6_q;
    lin2_d  = lin2_q;
    lin3_d  = lin3_q;
    if (wr_conv6) begin
      conv6_d = pwdata[`RCR_BYTE_HI:0] & `RCR_WMASK;
    end
    if (wr_lin2) begin
      lin2_d = pwdata[`RCR_BYTE_HI:0] & `RCR_WMASK;
    end
    if (wr_lin3) begin
      lin3_d = pwdata[`RCR_BYTE_HI:0] & `RCR_WMASK;
    end
  end

  // control register flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv6_q <= `RCR_RST_CONV6;
      lin2_q  <= `RCR_RST_LIN2;
      lin3_q  <= `RCR_RST_LIN3;
    end else begin
      conv6_q <= conv6_d;
      lin2_q  <= lin2_d;
      lin3_q  <= lin3_d;
    end
  end

  // read mux; the status word packs the per-rail decode results
  always @* begin
    prdata_d = 32'h0;
    if (is_reg(idx, `RCR_IDX_CONV6)) begin
      prdata_d = {24'h0, conv6_q};
    end else if (is_reg(idx, `RCR_IDX_LIN2)) begin
      prdata_d = {24'h0, lin2_q};
    end else if (is_reg(idx, `RCR_IDX_LIN3)) begin
      prdata_d = {24'h0, lin3_q};
    end else if (is_reg(idx, `RCR_IDX_STATUS)) begin
      prdata_d = {20'h0, bad, slp_d, on_d, sel_done_q, 2'h0};
    end
  end

  // read data taken in the setup cycle, so it stands from a flop in the access cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= prdata_d;
    end
  end

  // [RULE_11] each rail listens to its factory-chosen sleep pin
  assign rail_slp_n[0] = sel_q[0] ? slp_s_q[1] : slp_s_q[0];
  assign rail_slp_n[1] = sel_q[1] ? slp_s_q[1] : slp_s_q[0];
  assign rail_slp_n[2] = sel_q[2] ? slp_s_q[1] : slp_s_q[0];

  // converter six decode
  rcr_rail u_conv6 (
    .ctrl        (conv6_q),
    .en_pin      (en_s_q[0]),
    .sleep_pin_n (rail_slp_n[0]),
    .rail_on     (on_d[0]),
    .use_sleep   (slp_d[0]),
    .bad_code    (bad[0])
  );

  // linear two decode
  rcr_rail u_lin2 (
    .ctrl        (lin2_q),
    .en_pin      (en_s_q[1]),
    .sleep_pin_n (rail_slp_n[1]),
    .rail_on     (on_d[1]),
    .use_sleep   (slp_d[1]),
    .bad_code    (bad[1])
  );

  // linear three decode
  rcr_rail u_lin3 (
    .ctrl        (lin3_q),
    .en_pin      (en_s_q[2]),
    .sleep_pin_n (rail_slp_n[2]),
    .rail_on     (on_d[2]),
    .use_sleep   (slp_d[2]),
    .bad_code    (bad[2])
  );

  // registered rail controls
  // [RULE_04] mode bit to converter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rail_on_q          <= 3'h0;
      rail_sleep_q       <= 3'h0;
      conv_six_pwm_force <= 1'b0;
    end else begin
      rail_on_q          <= on_d;
      rail_sleep_q       <= slp_d;
      conv_six_pwm_force <= conv6_q[`RCR_MODE_BIT];
    end
  end
endmodule
`default_nettype wire

//--- bench/rcr_chk_asserts.sv
`default_nettype none
module rcr_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [2:0]  rail_on_q,
  input wire logic [2:0]  rail_sleep_q,
  input wire logic        conv_six_pwm_force
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read access of each control register
  wire logic       rd = psel && penable && !pwrite;
  wire logic [2:0] at = {paddr == 12'h0a4, paddr == 12'h0a0, paddr == 12'h09c};
  pwm_mode_a: assert property (rd && at[0] |-> conv_six_pwm_force == prdata[1])
    else $error("mode");
  conv_kill_a: assert property (rd && at[0] && !prdata[0] |-> !rail_on_q[0])
    else $error("kill0");
  lin2_kill_a: assert property (rd && at[1] && !prdata[0] |-> !rail_on_q[1])
    else $error("kill1");
  lin3_kill_a: assert property (rd && at[2] && !prdata[0] |-> !rail_on_q[2])
    else $error("kill2");
  conv_sleep_a: assert property (rd && at[0] && rail_sleep_q[0] |-> &prdata[5:4])
    else $error("slp0");
  lin2_sleep_a: assert property (rd && at[1] && rail_sleep_q[1] |-> &prdata[5:4])
    else $error("slp1");
  lin3_sleep_a: assert property (rd && at[2] && rail_sleep_q[2] |-> &prdata[5:4])
    else $error("slp2");
  top_zero_a: assert property (rd && at != 3'h0 |-> prdata[31:6] == 26'h0)
    else $error("rsvd");
  // write of the converter register, seen in its access cycle
  sequence conv_wr_s;
    psel && penable && pwrite && paddr == 12'h09c;
  endsequence
  // mode bit reaches the converter output one edge after the write lands
  property pwm_follow_p;
    conv_wr_s |=> ##1 (conv_six_pwm_force == $past(pwdata[1], 2));
  endproperty
  pwm_follow_a: assert property (pwm_follow_p)
    else $error("mode follow");
endmodule
bind rcr_top rcr_chk c_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .rail_on_q(rail_on_q),
  .rail_sleep_q(rail_sleep_q), .conv_six_pwm_force(conv_six_pwm_force));
`default_nettype wire

//--- bench/rail_control_registers_tb_top.sv
`default_nettype none
module rail_control_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, pwm, sp1 = 1'b0, sp2 = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  pins = 3'h7, on, slp;
  logic [32:0] rv;
  int          err_count = 0, num_checks = 0, cyc = 0;
  // rows: written bytes, read-back bytes, {on, sleep, pwm}
  logic [54:0] rows [2] = '{{24'h3c0c0c, 24'h3c0c0c, 7'h08}, {24'hcd3dff, 24'h0d3d3f, 7'h77}};
  // lin two listens to the second sleep pin, the other rails to the first
  rcr_top #(.SLEEP_PIN_SEL(3'h2)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rail_enable_pins(pins), .sleep_pin_first(sp1),
    .sleep_pin_second(sp2), .rail_on_q(on), .rail_sleep_q(slp), .conv_six_pwm_force(pwm));
  initial forever #4 clk = ~clk;
  // timeout watchdog
  always @(posedge clk) if (++cyc == 2000) begin
    err_count++;
    end_sim();
  end
  task automatic end_sim();
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  // one apb transfer, answer taken at the pready edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [32:0] q);
    @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = {pslverr, prdata};
    {psel, penable} <= 2'h0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 12'h09c, 32'h0, rv);
    chk(rv, 33'h0000000c);
    foreach (rows[i]) begin
      // rows keep the software write rules
      for (int r = 0; r < 3; r++) begin
        bus(1'b1, 12'h09c + 12'(4 * r), 32'(rows[i][31 + 8 * r +: 8]), rv);
      end
      for (int r = 0; r < 3; r++) begin
        bus(1'b0, 12'h09c + 12'(4 * r), 32'h0, rv);
        chk(rv, 33'(rows[i][7 + 8 * r +: 8]));
      end
      repeat (5) @(posedge clk);
      chk(33'({on, slp, pwm}), 33'(rows[i][6:0]));
    end
    // enables low, only second sleep pin low: nothing on, only lin two sleeps
    pins <= 3'h0;
    sp1 <= 1'b1;
    repeat (6) @(posedge clk);
    chk(33'({on, slp, pwm}), 33'h05);
    bus(1'b0, 12'h0b0, 32'h0, rv);
    chk(rv, 33'h100000000);
    // reset in mid-run: outputs cleared at once, registers back to reset value
    rst_n <= 1'b0;
    @(posedge clk);
    chk(33'({on, slp, pwm}), 33'h00);
    rst_n <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      bus(1'b0, 12'h09c + 12'(4 * r), 32'h0, rv);
      chk(rv, 33'h0000000c);
    end
    end_sim();
  end
endmodule
`default_nettype wire
